// ===== include/dcc_pkg.sv
// Constants shared by the modulo-ten counter cells and their APB wrapper.
// Assumes one 100 MHz clock and a 32-bit APB master.
package dcc_pkg;
   localparam int unsigned CNT_W      = 4;
   localparam logic [3:0]  CNT_LAST   = 4'h9;
   localparam logic [3:0]  CNT_ZERO   = 4'h0;
   localparam logic [3:0]  CNT_ONE    = 4'h1;
   localparam logic [3:0]  CNT_TOP    = 4'hf;
   localparam int unsigned ADDR_W     = 12;
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_PRESET = 12'h004;
   localparam logic [11:0] OFS_COUNTS = 12'h008;
   localparam logic [11:0] OFS_SEEN   = 12'h00c;
   localparam int unsigned CTRL_SW    = 0;
   localparam int unsigned CTRL_EN    = 1;
   localparam int unsigned CTRL_LOAD  = 2;
   localparam int unsigned SEEN_W     = 2;
   localparam logic        RST_SW     = 1'b0;
   localparam logic        RST_EN     = 1'b0;
   localparam logic [3:0]  RST_PRESET = 4'h0;
endpackage : dcc_pkg

// ===== design/dcc_cell.sv
// One four-bit modulo-ten counter cell; load and chain are options.
// Assumes load, enable and preset are synchronous to pclk.
`timescale 1ns/10ps
module dcc_cell #(
   parameter int unsigned WIDTH     = dcc_pkg::CNT_W,
   parameter bit          HAS_LOAD  = 1'b0,
   parameter bit          HAS_CHAIN = 1'b0
) (
   input  wire logic             pclk,
   input  wire logic             clear_n,
   input  wire logic             parallel_load,
   input  wire logic             chain_enable_in,
   input  wire logic [WIDTH-1:0] preset_value,
   output logic      [WIDTH-1:0] count_value,
   output logic                  terminal_pulse_out
);
   typedef struct packed
   {
      logic [3:0] count;
   } dcc_cell_st_t;

   dcc_cell_st_t st;
   dcc_cell_st_t next_st;
   logic         load;
   logic         advance;

   if (WIDTH != dcc_pkg::CNT_W)
   begin : g_bad_width
      $error("dcc_cell supports a four-bit count only");
   end

   always_comb
   begin
      load    = HAS_LOAD && parallel_load;
      advance = !HAS_CHAIN || chain_enable_in;
      next_st = st;
      if (load)
      begin
         next_st.count = preset_value;
      end
      else if (advance)
      begin
         if (st.count == dcc_pkg::CNT_LAST)
         begin
            next_st.count = dcc_pkg::CNT_ZERO;
         end
         else
         begin
            next_st.count = st.count + dcc_pkg::CNT_ONE;
         end
      end
   end

   always_ff @(posedge pclk or negedge clear_n)
   begin
      if (!clear_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign count_value        = st.count;
   assign terminal_pulse_out = HAS_CHAIN && chain_enable_in &&
                               st.count == dcc_pkg::CNT_LAST;
endmodule : dcc_cell

// ===== design/dcc_sticky.sv
// Sticky event flags with write-one-to-clear; a set beats a clear.
// Assumes set and clear are single-cycle pulses on pclk.
`timescale 1ns/10ps
module dcc_sticky #(
   parameter int unsigned N = dcc_pkg::SEEN_W
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] set,
   input  wire logic [N-1:0] clr,
   output logic      [N-1:0] flag
);
   typedef struct packed
   {
      logic [N-1:0] flag;
   } dcc_stk_st_t;

   dcc_stk_st_t st;
   dcc_stk_st_t next_st;

   if (N < 1)
   begin : g_bad_n
      $error("dcc_sticky needs at least one flag");
   end

   always_comb
   begin
      next_st      = st;
      next_st.flag = set | (st.flag & ~clr);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign flag = st.flag;
endmodule : dcc_sticky

// ===== design/dcc_top.sv
// Four modulo-ten counter cells with an APB register window.
// Assumes an APB master on pclk; cell pins are synchronous to pclk.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
module dcc_top #(
   parameter int unsigned ADDR_W = dcc_pkg::ADDR_W
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              cell_clear_n,
   input  wire logic              parallel_load,
   input  wire logic              chain_enable_in,
   input  wire logic [3:0]        preset_value,
   output logic      [3:0]        count_value_plain,
   output logic      [3:0]        count_value_preset,
   output logic      [3:0]        count_value_chain,
   output logic      [3:0]        count_value_both,
   output logic                   terminal_pulse_chain,
   output logic                   terminal_pulse_both
);
   typedef struct packed
   {
      logic        sw;
      logic        en;
      logic        load;
      logic [3:0]  preset;
      logic        ready;
      logic [31:0] rdata;
      logic        slverr;
   } dcc_top_st_t;

   dcc_top_st_t st;
   dcc_top_st_t next_st;

   logic        clr_n;
   logic        access;
   logic        wr;
   logic        mapped;
   logic [11:0] addr;
   logic        eff_load;
   logic        eff_en;
   logic [3:0]  eff_preset;
   logic [1:0]  seen;
   logic [1:0]  seen_set;
   logic [1:0]  seen_clr;

   if (ADDR_W < 4 || ADDR_W > 12)
   begin : g_bad_addr
      $error("dcc_top needs an address width of 4 to 12 bits");
   end

   // Clear from either the system reset or the cell clear pin
   assign clr_n = presetn & cell_clear_n;

   // Software takes over the cell inputs when the select bit is set
   assign eff_load   = st.sw ? st.load : parallel_load;
   assign eff_en     = st.sw ? st.en : chain_enable_in;
   assign eff_preset = st.sw ? st.preset : preset_value;

   dcc_cell #(
      .WIDTH     (dcc_pkg::CNT_W),
      .HAS_LOAD  (1'b0),
      .HAS_CHAIN (1'b0)
   ) u_plain (
      .pclk               (pclk),
      .clear_n            (clr_n),
      .parallel_load      (1'b0),
      .chain_enable_in    (1'b0),
      .preset_value       (4'h0),
      .count_value        (count_value_plain),
      .terminal_pulse_out ()
   );

   dcc_cell #(
      .WIDTH     (dcc_pkg::CNT_W),
      .HAS_LOAD  (1'b1),
      .HAS_CHAIN (1'b0)
   ) u_preset (
      .pclk               (pclk),
      .clear_n            (clr_n),
      .parallel_load      (eff_load),
      .chain_enable_in    (1'b0),
      .preset_value       (eff_preset),
      .count_value        (count_value_preset),
      .terminal_pulse_out ()
   );

   dcc_cell #(
      .WIDTH     (dcc_pkg::CNT_W),
      .HAS_LOAD  (1'b0),
      .HAS_CHAIN (1'b1)
   ) u_chain (
      .pclk               (pclk),
      .clear_n            (clr_n),
      .parallel_load      (1'b0),
      .chain_enable_in    (eff_en),
      .preset_value       (4'h0),
      .count_value        (count_value_chain),
      .terminal_pulse_out (terminal_pulse_chain)
   );

   dcc_cell #(
      .WIDTH     (dcc_pkg::CNT_W),
      .HAS_LOAD  (1'b1),
      .HAS_CHAIN (1'b1)
   ) u_both (
      .pclk               (pclk),
      .clear_n            (clr_n),
      .parallel_load      (eff_load),
      .chain_enable_in    (eff_en),
      .preset_value       (eff_preset),
      .count_value        (count_value_both),
      .terminal_pulse_out (terminal_pulse_both)
   );

   // Remembers that a terminal pulse met a clock edge
   assign seen_set = {terminal_pulse_both, terminal_pulse_chain};
   assign seen_clr = (wr && addr == dcc_pkg::OFS_SEEN) ?
                     pwdata[1:0] : 2'h0;

   dcc_sticky #(
      .N (dcc_pkg::SEEN_W)
   ) u_seen (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (seen_set),
      .clr     (seen_clr),
      .flag    (seen)
   );

   // One wait state: pready rises in the second access cycle
   assign addr   = 12'(paddr);
   assign access = psel && penable && st.ready;
   assign wr     = access && pwrite && mapped;
   assign mapped = addr == dcc_pkg::OFS_CTRL ||
                   addr == dcc_pkg::OFS_PRESET ||
                   addr == dcc_pkg::OFS_COUNTS ||
                   addr == dcc_pkg::OFS_SEEN;

   always_comb
   begin
      next_st        = st;
      next_st.load   = 1'b0;
      next_st.ready  = psel && penable && !st.ready;
      next_st.rdata  = 32'h0;
      next_st.slverr = 1'b0;
      if (psel && penable && !st.ready)
      begin
         next_st.slverr = !mapped;
         if (!pwrite)
         begin
            unique case (addr)
               dcc_pkg::OFS_CTRL:
                  next_st.rdata = {30'h0, st.en, st.sw};
               dcc_pkg::OFS_PRESET:
                  next_st.rdata = {28'h0, st.preset};
               dcc_pkg::OFS_COUNTS:
                  next_st.rdata = {16'h0, count_value_both,
                                   count_value_chain,
                                   count_value_preset,
                                   count_value_plain};
               dcc_pkg::OFS_SEEN:
                  next_st.rdata = {30'h0, seen};
               default:
                  next_st.rdata = 32'h0;
            endcase
         end
      end
      if (wr && addr == dcc_pkg::OFS_CTRL)
      begin
         next_st.sw   = pwdata[dcc_pkg::CTRL_SW];
         next_st.en   = pwdata[dcc_pkg::CTRL_EN];
         next_st.load = pwdata[dcc_pkg::CTRL_LOAD];
      end
      if (wr && addr == dcc_pkg::OFS_PRESET)
      begin
         next_st.preset = pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st        <= '0;
         st.sw     <= dcc_pkg::RST_SW;
         st.en     <= dcc_pkg::RST_EN;
         st.preset <= dcc_pkg::RST_PRESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign prdata  = st.rdata;
   assign pready  = st.ready;
   assign pslverr = st.slverr;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!clr_n);

   a_clear_forces_zero: assert property (
      disable iff (1'b0)
      !clr_n |-> count_value_plain == 4'h0 &&
                 count_value_preset == 4'h0 &&
                 count_value_chain == 4'h0 &&
                 count_value_both == 4'h0)
      else $error("count not zero under clear");

   a_plain_steps: assert property (
      count_value_plain != dcc_pkg::CNT_LAST
      |=> count_value_plain == $past(count_value_plain) + 4'h1)
      else $error("plain cell failed to advance");

   a_plain_wraps: assert property (
      count_value_plain == dcc_pkg::CNT_LAST
      |=> count_value_plain == dcc_pkg::CNT_ZERO)
      else $error("plain cell failed to wrap at nine");

   a_preset_loads: assert property (
      eff_load |=> count_value_preset == $past(eff_preset))
      else $error("preset cell missed a load");

   a_preset_resumes: assert property (
      eff_load ##1 (!eff_load && count_value_preset != 4'h9)
      |=> count_value_preset == $past(count_value_preset) + 4'h1)
      else $error("preset cell did not count on after load");

   a_preset_steps: assert property (
      !eff_load && count_value_preset != dcc_pkg::CNT_LAST
      |=> count_value_preset == $past(count_value_preset) + 4'h1)
      else $error("preset cell failed to advance");

   a_wide_wraps: assert property (
      !eff_load && count_value_preset == dcc_pkg::CNT_TOP
      |=> count_value_preset == dcc_pkg::CNT_ZERO)
      else $error("count above nine did not wrap after fifteen");

   a_chain_steps: assert property (
      eff_en && count_value_chain != dcc_pkg::CNT_LAST
      |=> count_value_chain == $past(count_value_chain) + 4'h1)
      else $error("chained cell failed to advance");

   a_chain_holds: assert property (
      !eff_en |=> $stable(count_value_chain))
      else $error("chained cell moved without enable");

   a_pulse_cause: assert property (
      terminal_pulse_chain ==
      (eff_en && count_value_chain == dcc_pkg::CNT_LAST))
      else $error("terminal pulse without nine and enable");

   a_pulse_single: assert property (
      terminal_pulse_chain |=> !terminal_pulse_chain &&
                               count_value_chain == 4'h0)
      else $error("terminal pulse longer than one cycle");

   a_both_loads: assert property (
      eff_load |=> count_value_both == $past(eff_preset))
      else $error("combined cell missed a load");

   a_load_over_en: assert property (
      eff_load && !eff_en |=> count_value_both == $past(eff_preset))
      else $error("combined load blocked by enable");

   a_both_steps: assert property (
      eff_en && !eff_load && count_value_both != 4'h9
      |=> count_value_both == $past(count_value_both) + 4'h1)
      else $error("combined cell failed to advance");

   a_both_holds: assert property (
      !eff_en && !eff_load |=> $stable(count_value_both))
      else $error("combined cell moved while idle");

   a_apb_wait: assert property (
      disable iff (!presetn)
      psel && penable && !pready |=> pready)
      else $error("pready late");

   c_plain_wrap: cover property (
      count_value_plain == 4'h9 ##1 count_value_plain == 4'h0);
   c_both_load: cover property (eff_load && !eff_en);
   c_chain_pulse: cover property (terminal_pulse_chain);
   c_apb_read: cover property (pready && !pwrite && psel);
endmodule : dcc_top

// ===== verif/dcc_far.sv
// Model of the synchronous logic that drives the cell pins.
// Assumes the bench seeds the random generator before the first test.
`timescale 1ns/10ps
module dcc_far (
   input  wire logic       pclk,
   input  wire logic       run,
   output logic            parallel_load,
   output logic            chain_enable_in,
   output logic      [3:0] preset_value
);
   initial
   begin
      parallel_load   = 1'b0;
      chain_enable_in = 1'b0;
      preset_value    = 4'h0;
   end

   // Changes only just after a rising edge, as synchronous logic would
   always @(posedge pclk)
   begin
      // Load drops before the next edge so counting resumes from the load
      parallel_load   <= run && ($urandom_range(3) == 0) && !parallel_load;
      chain_enable_in <= run && ($urandom_range(3) != 0);
      // Full four-bit range, codes above nine included
      preset_value    <= 4'($urandom_range(15));
   end
endmodule : dcc_far

// ===== verif/tb.sv
// Self-checking bench for the four modulo-ten cells and their registers.
// Assumes dcc_pkg, the design files and dcc_far are compiled first.
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
   begin \
      cmp_count++; \
      if ((got) !== (ex)) \
      begin \
         failures++; \
         $display("[ERR] %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic        clr_n   = 1'b1;
   logic        run     = 1'b0;
   logic        chk_on  = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        load;
   logic        en;
   logic [3:0]  pv;
   logic [3:0]  c_pl, c_pr, c_ch, c_bo;
   logic        tp_ch, tp_bo;
   logic [3:0]  m_pl, m_pr, m_ch, m_bo;
   logic [1:0]  m_seen;
   logic [31:0] rd;
   logic        er;
   int          failures  = 0;
   int          cmp_count = 0;
   wire         clr_all   = presetn & clr_n;

   dcc_top i_dcc_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cell_clear_n(clr_n),
      .parallel_load(load), .chain_enable_in(en), .preset_value(pv),
      .count_value_plain(c_pl), .count_value_preset(c_pr),
      .count_value_chain(c_ch), .count_value_both(c_bo),
      .terminal_pulse_chain(tp_ch), .terminal_pulse_both(tp_bo));

   dcc_far i_dcc_far (
      .pclk(pclk), .run(run), .parallel_load(load),
      .chain_enable_in(en), .preset_value(pv));

   function automatic logic [3:0] step(input logic [3:0] v);
      return (v == 4'h9) ? 4'h0 : v + 4'h1;
   endfunction : step

   always #5 pclk = ~pclk;

   // Reference cells, fed by the same pins as the design
   always @(posedge pclk or negedge clr_all)
   begin
      if (!clr_all)
      begin
         m_pl <= 4'h0;
         m_pr <= 4'h0;
         m_ch <= 4'h0;
         m_bo <= 4'h0;
      end
      else
      begin
         m_pl <= step(m_pl);
         m_pr <= load ? pv : step(m_pr);
         m_ch <= en ? step(m_ch) : m_ch;
         m_bo <= load ? pv : (en ? step(m_bo) : m_bo);
      end
   end

   always @(posedge pclk or negedge presetn)
      if (!presetn)
         m_seen <= 2'b00;
      else if (chk_on)
         m_seen <= m_seen | {m_bo == 4'h9 && en, m_ch == 4'h9 && en};

   always @(negedge pclk)
      if (presetn)
      begin
         `CHK("plain", m_pl, c_pl)
         if (chk_on)
         begin
            `CHK("preset", m_pr, c_pr)
            `CHK("chain", m_ch, c_ch)
            `CHK("both", m_bo, c_bo)
            `CHK("tp_chain", m_ch == 4'h9 && en, tp_ch)
            `CHK("tp_both", m_bo == 4'h9 && en, tp_bo)
         end
      end

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      begin
         @(posedge pclk);
         psel   <= 1'b1;
         pwrite <= w;
         paddr  <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         // Only the watchdog ends a wait that never sees pready
         while (pready !== 1'b1)
         begin
            @(posedge pclk);
         end
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic chk_rd(input logic [11:0] a, input logic [31:0] ex,
                         input logic ex_err);
      begin
         apb(1'b0, a, 32'h0);
         `CHK("rdata", ex, rd)
         `CHK("slverr", ex_err, er)
      end
   endtask : chk_rd

   task close_out;
      begin
         $display("compares %0d mismatches %0d", cmp_count, failures);
         if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask : close_out

   initial
   begin
      #(400000);
      failures++;
      close_out();
   end

   initial
   begin
      rd = $urandom(32'h65c3);
      // A real falling edge, so every async clear sees it before clock one
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk_rd(12'h000, 32'h0, 1'b0);
      chk_rd(12'h004, 32'h0, 1'b0);
      chk_on <= 1'b1;
      run    <= 1'b1;
      repeat (1500) @(posedge pclk);
      // Clear dropped just after an edge must act before the next edge
      @(posedge pclk);
      clr_n <= 1'b0;
      #1 `CHK("clr_async", 16'h0, {c_bo, c_ch, c_pr, c_pl})
      @(posedge pclk);
      #1 `CHK("clr_held", 16'h0, {c_bo, c_ch, c_pr, c_pl})
      @(posedge pclk);
      clr_n <= 1'b1;
      repeat (500) @(posedge pclk);
      run <= 1'b0;
      repeat (4) @(posedge pclk);
      chk_rd(12'h00c, {30'h0, m_seen}, 1'b0);
      apb(1'b1, 12'h00c, 32'h3);
      chk_rd(12'h00c, 32'h0, 1'b0);
      chk_rd(12'h010, 32'h0, 1'b1);
      chk_rd(12'h002, 32'h0, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      `CHK("hold", {m_bo, m_ch}, rd[15:8])
      // Software drives the cells: load 7 with enable low, then count
      chk_on <= 1'b0;
      apb(1'b1, 12'h004, 32'h7);
      apb(1'b1, 12'h000, 32'h5);
      chk_rd(12'h000, 32'h1, 1'b0);
      apb(1'b0, 12'h008, 32'h0);
      `CHK("sw_load", 4'h7, rd[15:12])
      `CHK("sw_hold", m_ch, rd[11:8])
      apb(1'b1, 12'h000, 32'h3);
      repeat (3) @(posedge pclk);
      apb(1'b1, 12'h000, 32'h0);
      clr_n <= 1'b0;
      @(posedge pclk);
      clr_n  <= 1'b1;
      chk_on <= 1'b1;
      run    <= 1'b1;
      repeat (300) @(posedge pclk);
      close_out();
   end
endmodule : tb
